/* rtl/piob_regs.sv */
// io base address register bank of function 0 with io cycle decode
`timescale 1ns/1ps
`default_nettype none
module piob_regs (
   input wire logic clk_sys,
   input wire logic rst,
   input wire piob_pkg::piob_cfg_req_t cfg_req,
   output var logic [31:0] cfg_rdata,
   output var logic cfg_ack,
   input wire logic io_valid,
   input wire logic [31:0] io_addr,
   output var piob_pkg::piob_io_sel_t io_sel,
   output var logic io_claim,
   output var logic [6:0] io_offset
);
   logic [31:piob_pkg::LSB_NONLEGACY] nl_base;
   logic [31:piob_pkg::LSB_GAME] game_base;
   logic [31:piob_pkg::LSB_MIDI] midi_base;
   logic [31:piob_pkg::LSB_FM] fm_base;

   // function and offset decode of configuration accesses
   wire logic cfg_fn0 = cfg_req.valid && (cfg_req.func == piob_pkg::FUNC_AUDIO);
   wire logic sel_nl = cfg_fn0 && (cfg_req.offset == piob_pkg::OFS_NONLEGACY);
   wire logic sel_game = cfg_fn0 && (cfg_req.offset == piob_pkg::OFS_GAME);
   wire logic sel_midi = cfg_fn0 && (cfg_req.offset == piob_pkg::OFS_MIDI);
   wire logic sel_fm = cfg_fn0 && (cfg_req.offset == piob_pkg::OFS_FM);
   wire logic do_wr = cfg_req.write;

   // byte-lane merge of write data into the current register image
   function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] res;
      res = cur;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // read images: reserved bits zero, io flag one
   wire logic [31:0] img_nl = {nl_base, 6'h00, 1'b1};
   wire logic [31:0] img_game = {game_base, 3'h0, 1'b1};
   wire logic [31:0] img_midi = {midi_base, 1'b0, 1'b1};
   wire logic [31:0] img_fm = {fm_base, 2'h0, 1'b1};
   wire logic [31:0] mg_nl = merge(img_nl, cfg_req.wdata, cfg_req.be);
   wire logic [31:0] mg_game = merge(img_game, cfg_req.wdata, cfg_req.be);
   wire logic [31:0] mg_midi = merge(img_midi, cfg_req.wdata, cfg_req.be);
   wire logic [31:0] mg_fm = merge(img_fm, cfg_req.wdata, cfg_req.be);
   wire logic [31:0] next_rdata = sel_nl ? img_nl : sel_game ? img_game :
                                  sel_midi ? img_midi : sel_fm ? img_fm : 32'h0000_0000;

   // base field storage; only writable bits are kept
   // bit 0 and the reserved bits have no flops, so writes to them simply fall away
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nl_base <= piob_pkg::BASE_RESET[31:piob_pkg::LSB_NONLEGACY];
         game_base <= piob_pkg::BASE_RESET[31:piob_pkg::LSB_GAME];
         midi_base <= piob_pkg::BASE_RESET[31:piob_pkg::LSB_MIDI];
         fm_base <= piob_pkg::BASE_RESET[31:piob_pkg::LSB_FM];
      end else if (do_wr) begin
         if (sel_nl) nl_base <= mg_nl[31:piob_pkg::LSB_NONLEGACY];
         if (sel_game) game_base <= mg_game[31:piob_pkg::LSB_GAME];
         if (sel_midi) midi_base <= mg_midi[31:piob_pkg::LSB_MIDI];
         if (sel_fm) fm_base <= mg_fm[31:piob_pkg::LSB_FM];
      end
   end

   // configuration read data and acknowledge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_rdata <= 32'h0000_0000;
         cfg_ack <= 1'b0;
      end else begin
         cfg_rdata <= (cfg_req.valid && !do_wr) ? next_rdata : 32'h0000_0000;
         cfg_ack <= cfg_req.valid;
      end
   end

   // a zero base after reset still decodes address zero; software programs the bases before io
   // io range compare against each base field
   wire logic hit_nl = io_valid && (io_addr[31:piob_pkg::LSB_NONLEGACY] == nl_base);
   wire logic hit_game = io_valid && (io_addr[31:piob_pkg::LSB_GAME] == game_base);
   wire logic hit_midi = io_valid && (io_addr[31:piob_pkg::LSB_MIDI] == midi_base);
   wire logic hit_fm = io_valid && (io_addr[31:piob_pkg::LSB_FM] == fm_base);
   wire logic [6:0] nl_off = io_addr[6:0];
   // non-legacy sub-device decode at fixed offsets
   wire logic in_timer = hit_nl && (nl_off < piob_pkg::NL_SERIAL);
   wire logic in_serial = hit_nl && (nl_off >= piob_pkg::NL_SERIAL) && (nl_off < piob_pkg::NL_HOSTDSP);
   wire logic in_hostdsp = hit_nl && (nl_off >= piob_pkg::NL_HOSTDSP) && (nl_off < piob_pkg::NL_CODEC);
   wire logic in_codec = hit_nl && (nl_off >= piob_pkg::NL_CODEC) && (nl_off < piob_pkg::NL_IRQCTL);
   wire logic in_irq = hit_nl && (nl_off >= piob_pkg::NL_IRQCTL) && (nl_off < piob_pkg::NL_END);
   wire logic any_hit = in_timer | in_serial | in_hostdsp | in_codec | in_irq | hit_game | hit_midi | hit_fm;
   // fm hits steer to game-audio register subset, low bits as offset
   wire logic [6:0] next_off = hit_nl ? nl_off :
                               hit_fm ? {4'h0, io_addr[2:0]} :
                               hit_game ? {3'h0, io_addr[3:0]} :
                               hit_midi ? {5'h00, io_addr[1:0]} : 7'h00;

   // registered decode outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         io_sel <= '0;
         io_claim <= 1'b0;
         io_offset <= 7'h00;
      end else begin
         io_sel.hit_timer <= in_timer;
         io_sel.hit_serial <= in_serial;
         io_sel.hit_hostdsp <= in_hostdsp;
         io_sel.hit_codec <= in_codec;
         io_sel.hit_irqctl <= in_irq;
         io_sel.hit_game <= hit_game | hit_fm;
         io_sel.hit_midi <= hit_midi;
         io_sel.hit_fm <= hit_fm;
         io_claim <= any_hit;
         io_offset <= next_off;
      end
   end

   // assertions
   sequence cfg_rd_s(logic [7:0] ofs);
      cfg_req.valid && !cfg_req.write && cfg_req.func == piob_pkg::FUNC_AUDIO && cfg_req.offset == ofs;
   endsequence
   nl_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_rd_s(piob_pkg::OFS_NONLEGACY) |=> cfg_rdata[6:0] == 7'h01) else $error("nonlegacy low bits wrong");
   game_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_rd_s(piob_pkg::OFS_GAME) |=> cfg_rdata[3:0] == 4'h1) else $error("game low bits wrong");
   midi_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_rd_s(piob_pkg::OFS_MIDI) |=> cfg_rdata[1:0] == 2'h1) else $error("midi low bits wrong");
   fm_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_rd_s(piob_pkg::OFS_FM) |=> cfg_rdata[2:0] == 3'h1) else $error("fm low bits wrong");
   nl_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      sel_nl && do_wr && cfg_req.be == 4'hf |=> nl_base == $past(cfg_req.wdata[31:7])) else $error("nl write lost");
   other_fn_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_req.valid && cfg_req.func != piob_pkg::FUNC_AUDIO |=> $stable(nl_base) && $stable(game_base))
      else $error("other function wrote base");
   reset_val_a: assert property (@(posedge clk_sys)
      rst |=> nl_base == '0 && game_base == '0 && midi_base == '0 && fm_base == '0) else $error("reset value");
   claim_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_valid && io_addr[31:2] == midi_base |=> io_claim && io_sel.hit_midi) else $error("midi not claimed");
   fm_map_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_valid && io_addr[31:3] == fm_base |=> io_sel.hit_game) else $error("fm not mapped to game");
   timer_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_valid && io_addr[31:7] == nl_base && io_addr[6:4] == 3'h0 |=> io_sel.hit_timer) else $error("timer decode");

   // full-word write to one function 0 register, used by the write-back checks
   sequence cfg_wr_s(logic [7:0] ofs);
      cfg_req.valid && cfg_req.write && cfg_req.func == piob_pkg::FUNC_AUDIO && cfg_req.offset == ofs &&
         cfg_req.be == 4'hf;
   endsequence
   // io address inside one 16-byte block of the non-legacy range
   sequence io_nl_s(logic [2:0] blk);
      io_valid && io_addr[31:piob_pkg::LSB_NONLEGACY] == nl_base && io_addr[6:4] == blk;
   endsequence

   // legacy base fields take the written address bits and nothing below them
   game_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_wr_s(piob_pkg::OFS_GAME) |=> game_base == $past(cfg_req.wdata[31:4])) else $error("game write lost");
   midi_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_wr_s(piob_pkg::OFS_MIDI) |=> midi_base == $past(cfg_req.wdata[31:2])) else $error("midi write lost");
   fm_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_wr_s(piob_pkg::OFS_FM) |=> fm_base == $past(cfg_req.wdata[31:3])) else $error("fm write lost");
   // a write to the game register leaves the other three alone
   sep_regs_a: assert property (@(posedge clk_sys) disable iff (rst)
      sel_game && do_wr |=> $stable(midi_base) && $stable(fm_base) && $stable(nl_base))
      else $error("game write disturbed another base");
   // a cleared byte enable keeps that byte of the field
   be_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
      sel_nl && do_wr && !cfg_req.be[3] |=> $stable(nl_base[31:24])) else $error("disabled byte lane written");

   // every configuration cycle is acknowledged one cycle later, whatever its function
   ack_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_req.valid |=> cfg_ack) else $error("config cycle not acknowledged");
   no_ack_a: assert property (@(posedge clk_sys) disable iff (rst)
      !cfg_req.valid |=> !cfg_ack) else $error("acknowledge without request");
   other_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
      cfg_req.valid && !cfg_req.write && cfg_req.func != piob_pkg::FUNC_AUDIO |=> cfg_rdata == 32'h0000_0000)
      else $error("other function read not zero");
   // outputs fall quiet while reset is applied
   out_reset_a: assert property (@(posedge clk_sys)
      rst |=> !cfg_ack && !io_claim && cfg_rdata == 32'h0000_0000) else $error("outputs not cleared by reset");

   // the 16-byte blocks at 0x10, 0x20 and 0x30 and the 4-byte block at 0x40 of the non-legacy range each select their own sub-device
   serial_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_nl_s(3'h1) |=> io_sel.hit_serial) else $error("serial decode");
   hostdsp_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_nl_s(3'h2) |=> io_sel.hit_hostdsp) else $error("host dsp decode");
   codec_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_nl_s(3'h3) |=> io_sel.hit_codec) else $error("codec decode");
   irq_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_valid && io_addr[31:7] == nl_base && io_addr[6:2] == 5'h10 |=> io_sel.hit_irqctl)
      else $error("irq decode");
   // the unused top of the non-legacy range is never claimed as a sub-device
   nl_gap_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_valid && io_addr[31:7] == nl_base && io_addr[6:0] >= piob_pkg::NL_END
      |=> !(io_sel.hit_timer || io_sel.hit_serial || io_sel.hit_hostdsp || io_sel.hit_codec || io_sel.hit_irqctl))
      else $error("non-legacy gap claimed");
   game_claim_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_valid && io_addr[31:4] == game_base |=> io_claim && io_sel.hit_game) else $error("game not claimed");
   idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      !io_valid |=> !io_claim && io_sel == '0) else $error("claim without io cycle");
   // fm accesses pass their low three address bits as the register offset
   fm_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_valid && io_addr[31:3] == fm_base && io_addr[31:7] != nl_base
      |=> io_offset == {4'h0, $past(io_addr[2:0])}) else $error("fm offset wrong");
   // game accesses pass their low four address bits unless a higher-priority range also hits
   game_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      io_valid && io_addr[31:4] == game_base && io_addr[31:7] != nl_base && io_addr[31:3] != fm_base
      |=> io_offset == {3'h0, $past(io_addr[3:0])}) else $error("game offset wrong");
endmodule : piob_regs
`default_nettype wire

/* shared/piob_pkg.sv */
// package: register offsets, field layouts and carrier structs for the io base register bank
package piob_pkg;
   // configuration offsets (byte addresses in function 0 header)
   localparam logic [7:0] OFS_NONLEGACY = 8'h10;
   localparam logic [7:0] OFS_GAME = 8'h14;
   localparam logic [7:0] OFS_MIDI = 8'h18;
   localparam logic [7:0] OFS_FM = 8'h1c;
   // lowest writable bit of each base field
   localparam int LSB_NONLEGACY = 7;
   localparam int LSB_GAME = 4;
   localparam int LSB_MIDI = 2;
   localparam int LSB_FM = 3;
   // io flag position and value after reset of base fields
   localparam int IO_FLAG_BIT = 0;
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   localparam logic [2:0] FUNC_AUDIO = 3'h0;
   // fixed offsets of sub-devices behind the non-legacy base
   localparam logic [6:0] NL_TIMER = 7'h00;
   localparam logic [6:0] NL_SERIAL = 7'h10;
   localparam logic [6:0] NL_HOSTDSP = 7'h20;
   localparam logic [6:0] NL_CODEC = 7'h30;
   localparam logic [6:0] NL_IRQCTL = 7'h40;
   localparam logic [6:0] NL_END = 7'h44;

   // configuration access from the pci target core
   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] func;
      logic [7:0] offset;
      logic [3:0] be;
      logic [31:0] wdata;
   } piob_cfg_req_t;

   // io-space decode result
   typedef struct packed {
      logic hit_timer;
      logic hit_serial;
      logic hit_hostdsp;
      logic hit_codec;
      logic hit_irqctl;
      logic hit_game;
      logic hit_midi;
      logic hit_fm;
   } piob_io_sel_t;
endpackage : piob_pkg

/* dv/piob_host.sv */
// host model issuing configuration and io cycles to the base register bank
`timescale 1ns/1ps
`default_nettype none
module piob_host (
   input wire logic clk_sys,
   output var piob_pkg::piob_cfg_req_t cfg_req,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   output logic io_valid,
   output logic [31:0] io_addr,
   input wire piob_pkg::piob_io_sel_t io_sel,
   input wire logic io_claim,
   input wire logic [6:0] io_offset
);
   // byte enables of the next config access; the bench narrows them for lane tests
   logic [3:0] cfg_be = 4'hf;
   initial begin
      cfg_req = '0;
      io_valid = 1'b0;
      io_addr = 32'h0000_0000;
   end
   // one config access, answer taken one edge later; function field picks the header
   task automatic cfg(input logic [2:0] fn, input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
         output logic [32:0] ans);
      @(posedge clk_sys);
      #1;
      cfg_req = '{valid: 1'b1, write: wr, func: fn, offset: ofs, be: cfg_be, wdata: wd};
      @(posedge clk_sys);
      #1;
      ans = {cfg_ack, cfg_rdata};
      cfg_req.valid = 1'b0;
      cfg_req.wdata = ~wd; // released data does not linger
   endtask : cfg
   // one io address phase, software only places aligned bases
   task automatic io(input logic [31:0] a, output logic [15:0] ans);
      @(posedge clk_sys);
      #1;
      io_valid = 1'b1;
      io_addr = a;
      @(posedge clk_sys);
      #1;
      ans = {io_claim, io_sel, io_offset};
      io_valid = 1'b0;
      io_addr = ~a;
   endtask : io
endmodule : piob_host
`default_nettype wire

/* dv/test_pci_io_base_address_regs.sv */
// testbench for the io base register bank
`timescale 1ns/1ps
`default_nettype none
module test_pci_io_base_address_regs;
   logic clk_sys;
   logic rst;
   piob_pkg::piob_cfg_req_t cfg_req;
   logic [31:0] cfg_rdata;
   logic cfg_ack;
   logic io_valid;
   logic [31:0] io_addr;
   piob_pkg::piob_io_sel_t io_sel;
   logic io_claim;
   logic [6:0] io_offset;
   int errors = 0;
   int tests_run = 0;
   logic [32:0] ca;
   logic [15:0] ia;
   logic [7:0] ofs [4] = '{piob_pkg::OFS_NONLEGACY, piob_pkg::OFS_GAME, piob_pkg::OFS_MIDI, piob_pkg::OFS_FM};
   logic [31:0] ones [4] = '{32'hffff_ff81, 32'hffff_fff1, 32'hffff_fffd, 32'hffff_fff9};
   logic [31:0] bases [4] = '{32'h0000_1000, 32'h0000_0220, 32'h0000_0330, 32'h0000_0388};
   // clock generation
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   piob_regs u_piob_regs (.clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .io_valid(io_valid), .io_addr(io_addr), .io_sel(io_sel), .io_claim(io_claim),
      .io_offset(io_offset));
   piob_host u_piob_host (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .io_valid(io_valid), .io_addr(io_addr), .io_sel(io_sel), .io_claim(io_claim), .io_offset(io_offset));
   // compare and count
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   // watchdog
   initial begin
      #50us;
      errors++;
      close_out();
   end
   // test sequence
   initial begin
      rst = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         u_piob_host.cfg(3'h0, 1'b0, ofs[i], 32'h0, ca);
         check(ca, {1'b1, 32'h0000_0001});
         u_piob_host.cfg(3'h0, 1'b1, ofs[i], 32'hffff_fffe, ca);
         check(ca, {1'b1, 32'h0000_0000});
         u_piob_host.cfg(3'h0, 1'b0, ofs[i], 32'h0, ca);
         check(ca, {1'b1, ones[i]});
      end
      $display("reset and field widths done");
      u_piob_host.cfg(3'h1, 1'b1, piob_pkg::OFS_GAME, 32'h0, ca);
      u_piob_host.cfg(3'h1, 1'b0, piob_pkg::OFS_GAME, 32'h0, ca);
      check(ca, {1'b1, 32'h0});
      u_piob_host.cfg(3'h0, 1'b0, piob_pkg::OFS_GAME, 32'h0, ca);
      check(ca, {1'b1, ones[1]});
      $display("other function done");
      u_piob_host.cfg_be = 4'h1;
      u_piob_host.cfg(3'h0, 1'b1, piob_pkg::OFS_NONLEGACY, 32'h0000_0000, ca);
      u_piob_host.cfg_be = 4'h2;
      u_piob_host.cfg(3'h0, 1'b1, piob_pkg::OFS_GAME, 32'h0000_0000, ca);
      u_piob_host.cfg_be = 4'hf;
      u_piob_host.cfg(3'h0, 1'b0, piob_pkg::OFS_NONLEGACY, 32'h0, ca);
      check(ca, {1'b1, 32'hffff_ff01});
      u_piob_host.cfg(3'h0, 1'b0, piob_pkg::OFS_GAME, 32'h0, ca);
      check(ca, {1'b1, 32'hffff_00f1});
      $display("byte lanes done");
      for (int i = 0; i < 4; i++) u_piob_host.cfg(3'h0, 1'b1, ofs[i], bases[i], ca);
      u_piob_host.io(32'h0000_1020, ia);
      check(ia, {1'b1, 8'h20, 7'h20});
      u_piob_host.io(32'h0000_1040, ia);
      check(ia, {1'b1, 8'h08, 7'h40});
      u_piob_host.io(32'h0000_1044, ia);
      check(ia[15], 1'b0);
      u_piob_host.io(32'h0000_038a, ia);
      check(ia, {1'b1, 8'h05, 7'h02});
      u_piob_host.io(32'h0000_0331, ia);
      check(ia, {1'b1, 8'h02, 7'h01});
      u_piob_host.io(32'h0000_022f, ia);
      check(ia, {1'b1, 8'h04, 7'h0f});
      u_piob_host.io(32'h0000_0230, ia);
      check(ia[15], 1'b0);
      u_piob_host.io(32'h0000_1000, ia);
      check(ia, {1'b1, 8'h80, 7'h00});
      u_piob_host.io(32'h0000_1014, ia);
      check(ia, {1'b1, 8'h40, 7'h14});
      u_piob_host.io(32'h0000_103c, ia);
      check(ia, {1'b1, 8'h10, 7'h3c});
      $display("io decode done");
      @(posedge clk_sys);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         u_piob_host.cfg(3'h0, 1'b0, ofs[i], 32'h0, ca);
         check(ca, {1'b1, 32'h0000_0001});
      end
      $display("mid-run reset done");
      close_out();
   end
endmodule : test_pci_io_base_address_regs
`default_nettype wire
